// >>> logic/fram_pkg.sv
// ******************************************************************
// Shared constants and types of the serial memory command block
// ******************************************************************
package fram_pkg;

  // Array geometry: nine address bits, 512 bytes
  localparam int ADDR_W = 9;
  localparam int DEPTH  = 512;

  // Opcodes; bit 3 of read and write carries the ninth address bit
  localparam logic [7:0] OPC_WRITE_LO   = 8'h02;
  localparam logic [7:0] OPC_WRITE_HI   = 8'h0a;
  localparam logic [7:0] OPC_READ_LO    = 8'h03;
  localparam logic [7:0] OPC_READ_HI    = 8'h0b;
  localparam logic [7:0] OPC_SET_LATCH  = 8'h06;
  localparam logic [7:0] OPC_CLR_LATCH  = 8'h04;
  localparam logic [7:0] OPC_STATUS_RD  = 8'h05;
  localparam logic [7:0] OPC_STATUS_WR  = 8'h01;
  localparam int         OPC_MSB_POS    = 3;

  // Status byte layout and reset value
  localparam int         ST_LATCH_POS   = 1;
  localparam int         ST_BP_LO_POS   = 2;
  localparam int         ST_BP_HI_POS   = 3;
  localparam logic [7:0] STATUS_RESET   = 8'h00;

  typedef struct packed {
    logic [3:0] zero_hi;
    logic       protect_select_hi;
    logic       protect_select_lo;
    logic       write_latch_flag;
    logic       zero_lo;
  } status_t;

  // Kind of write seen in the current frame
  typedef enum logic [1:0] {
    KIND_NONE, KIND_MEM_LO, KIND_MEM_HI, KIND_STATUS
  } frame_kind_t;

  // Position of the serial link within a frame
  typedef enum logic [1:0] {
    PH_OPCODE, PH_ADDR, PH_DATA, PH_IGNORE
  } link_phase_t;

  function automatic logic is_mem_write(input logic [7:0] op);
    return (op[7:4] == 4'h0) && (op[2:0] == 3'h2);
  endfunction

  function automatic logic is_mem_read(input logic [7:0] op);
    return (op[7:4] == 4'h0) && (op[2:0] == 3'h3);
  endfunction

endpackage

// >>> logic/bit_sync.sv
`timescale 1ns/1ns
// ******************************************************************
// Two-stage synchroniser for independent level bits
// ******************************************************************
module bit_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  // First stage feeds only the second stage
  always_comb begin
    meta_next = rst ? '0 : d;
    q_next    = rst ? '0 : meta_reg;
  end

  always_ff @(posedge clk) begin
    meta_reg <= meta_next;
    q        <= q_next;
  end
endmodule

// >>> logic/fram_array.sv
`timescale 1ns/1ns
// ******************************************************************
// Byte array on the link clock: one write port, one async read port
// ******************************************************************
module fram_array (
  input  wire logic                        clk,
  input  wire logic                        we,
  input  wire logic [fram_pkg::ADDR_W-1:0] waddr,
  input  wire logic [7:0]                  wdata,
  input  wire logic [fram_pkg::ADDR_W-1:0] raddr,
  output logic      [7:0]                  rdata
);
  import fram_pkg::*;
  logic [7:0] mem [DEPTH];

  // Asynchronous read lets the next byte leave on the very next edge
  always_comb begin
    rdata = mem[raddr];
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
endmodule

// >>> logic/spi_fram_write_latch_ctrl.sv
`timescale 1ns/1ns
// Overview of operation
// - Set-latch opcode sets the write latch; status bit shows it.
// - Status write data never alters the latch flag.
// - Finished 0x02 memory write or status write clears the latch automatically.
// - Latch flag is status bit 1, zero after power-up.
// - Status bits 0 and 4..7 ignore writes and read zero.
// - Status bits 2 and 3 are writable protect selectors, reset zero.
// - Ninth address bit comes from opcode bit 3.
// - Memory write opcodes are 0x02 low half, 0x0a high half.
// - Memory read opcodes are 0x03 low half, 0x0b high half.
// - A finished 0x0a write leaves the latch set.
// - That still-set latch lets later writes through without re-enable.
// - Clear-latch opcode clears the latch and blocks writes.
module spi_fram_write_latch_ctrl (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic si,
  output logic      so_out,
  output logic      so_oe,
  output logic      write_latch_flag
);
  import fram_pkg::*;

  // ****************************************************************
  // Link side: serial shifter and command decode on sclk
  // ****************************************************************

  logic [2:0]        bit_cnt_reg,   bit_cnt_next;
  logic [6:0]        shift_reg,     shift_next;
  link_phase_t       phase_reg,     phase_next;
  logic [7:0]        opcode_reg,    opcode_next;
  logic [ADDR_W-1:0] addr_reg,      addr_next;
  logic              opc_seen_reg,  opc_seen_next;
  logic              sr_seen_reg,   sr_seen_next;
  logic [7:0]        sr_data_reg,   sr_data_next;
  logic [7:0]        byte_in;
  logic              byte_done;
  logic              mem_we;
  logic [7:0]        mem_rdata;
  logic [2:0]        link_lvl;
  status_t           status_link;
  logic [7:0]        tx_byte;
  logic              so_next;
  logic              so_oe_next;
  logic              frame_start;
  status_t           status_q;

  assign byte_in     = {shift_reg, si};
  assign byte_done   = (bit_cnt_reg == 3'h7);
  assign frame_start = (bit_cnt_reg == 3'h0) && (phase_reg == PH_OPCODE);

  // Latch and protect bits arrive as slow levels; the opcode byte alone
  // gives eight edges, so the copy is settled before any data byte
  bit_sync #(.W(3)) u_lvl_sync (
    .clk (sclk),
    .rst (1'b0),
    .d   ({status_q.protect_select_hi, status_q.protect_select_lo,
           status_q.write_latch_flag}),
    .q   (link_lvl)
  );

  assign status_link = '{zero_hi: 4'h0, protect_select_hi: link_lvl[2],
                         protect_select_lo: link_lvl[1],
                         write_latch_flag: link_lvl[0], zero_lo: 1'b0};

  fram_array u_array (
    .clk   (sclk),
    .we    (mem_we),
    .waddr (addr_reg),
    .wdata (byte_in),
    .raddr (addr_reg),
    .rdata (mem_rdata)
  );

  // Byte assembly and phase steps, all on the rising edge
  always_comb begin
    bit_cnt_next = bit_cnt_reg + 3'h1;
    shift_next   = byte_in[6:0];
    phase_next   = phase_reg;
    opcode_next  = opcode_reg;
    addr_next    = addr_reg;
    opc_seen_next = opc_seen_reg;
    sr_seen_next  = sr_seen_reg;
    sr_data_next  = sr_data_reg;
    mem_we        = 1'b0;
    // Flags stay up through the gap so the control side always sees
    // them, and drop at the first rise of the next frame
    if (frame_start) begin
      opc_seen_next = 1'b0;
      sr_seen_next  = 1'b0;
    end
    if (byte_done) begin
      unique case (phase_reg)
        PH_OPCODE: begin
          opcode_next  = byte_in;
          opc_seen_next = 1'b1;
          if (is_mem_write(byte_in) || is_mem_read(byte_in)) begin
            phase_next        = PH_ADDR;
            addr_next[ADDR_W-1] = byte_in[OPC_MSB_POS];
          end else if (byte_in == OPC_STATUS_WR ||
                       byte_in == OPC_STATUS_RD) begin
            phase_next = PH_DATA;
          end else begin
            phase_next = PH_IGNORE;
          end
        end
        PH_ADDR: begin
          addr_next[ADDR_W-2:0] = byte_in;
          phase_next            = PH_DATA;
        end
        PH_DATA: begin
          if (is_mem_write(opcode_reg)) begin
            mem_we    = status_link.write_latch_flag;
            addr_next = addr_reg + 9'h001;
          end else if (is_mem_read(opcode_reg)) begin
            addr_next = addr_reg + 9'h001;
          end else if (opcode_reg == OPC_STATUS_WR) begin
            // Only the first data byte counts, so the held word stays put
            sr_data_next = byte_in;
            sr_seen_next = 1'b1;
            phase_next   = PH_IGNORE;
          end
        end
        PH_IGNORE: begin
          phase_next = PH_IGNORE;
        end
      endcase
    end
  end

  // Chip select high ends the frame; the clock may stop right after
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_reg <= 3'h0;
      phase_reg   <= PH_OPCODE;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      phase_reg   <= phase_next;
    end
  end

  // Flags and the words they announce survive the frame end
  always_ff @(posedge sclk) begin
    shift_reg    <= shift_next;
    opcode_reg   <= opcode_next;
    addr_reg     <= addr_next;
    opc_seen_reg <= opc_seen_next;
    sr_seen_reg  <= sr_seen_next;
    sr_data_reg  <= sr_data_next;
  end

  // Read data leaves on the falling edge, MSB first
  always_comb begin
    tx_byte    = (opcode_reg == OPC_STATUS_RD) ? status_link : mem_rdata;
    so_next    = tx_byte[3'h7 - bit_cnt_reg];
    so_oe_next = (phase_reg == PH_DATA) &&
                 (is_mem_read(opcode_reg) ||
                  opcode_reg == OPC_STATUS_RD);
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      so_out <= 1'b0;
      so_oe  <= 1'b0;
    end else begin
      so_out <= so_next;
      so_oe  <= so_oe_next;
    end
  end

  // ****************************************************************
  // Control side: write latch and status register on mclk
  // ****************************************************************

  logic [2:0]  evt_sync;
  logic [2:0]  evt_prev_reg, evt_prev_next;
  logic        latch_reg,    latch_next;
  logic [1:0]  bp_reg,       bp_next;
  frame_kind_t kind_reg,     kind_next;
  logic        opc_evt, sr_evt, frame_end;

  // Flags cross as levels that stay up between frames; the select level idles
  // low, like the synchroniser's reset value, so no false frame end follows reset
  bit_sync #(.W(3)) u_evt_sync (
    .clk (mclk),
    .rst (rst),
    .d   ({~cs_n, sr_seen_reg, opc_seen_reg}),
    .q   (evt_sync)
  );

  assign opc_evt   = evt_sync[0] & ~evt_prev_reg[0];
  assign sr_evt    = evt_sync[1] & ~evt_prev_reg[1];
  assign frame_end = ~evt_sync[2] & evt_prev_reg[2];

  assign status_q = '{zero_hi: 4'h0, protect_select_hi: bp_reg[1],
                      protect_select_lo: bp_reg[0],
                      write_latch_flag: latch_reg, zero_lo: 1'b0};

  // Events are taken in frame order: opcode, data, then chip select
  always_comb begin
    evt_prev_next = evt_sync;
    latch_next    = latch_reg;
    bp_next       = bp_reg;
    kind_next     = kind_reg;
    if (opc_evt) begin
      if (opcode_reg == OPC_SET_LATCH) begin
        latch_next = 1'b1;
      end else if (opcode_reg == OPC_CLR_LATCH) begin
        latch_next = 1'b0;
      end
      if (opcode_reg == OPC_WRITE_LO) begin
        kind_next = KIND_MEM_LO;
      end else if (opcode_reg == OPC_WRITE_HI) begin
        kind_next = KIND_MEM_HI;
      end else if (opcode_reg == OPC_STATUS_WR) begin
        kind_next = KIND_STATUS;
      end else begin
        kind_next = KIND_NONE;
      end
    end
    // Only the selectors take data; latch flag is never written here
    if (sr_evt && latch_next) begin
      bp_next = {sr_data_reg[ST_BP_HI_POS],
                 sr_data_reg[ST_BP_LO_POS]};
    end
    if (frame_end) begin
      // Upper-half write keeps the latch, as the silicon does
      if (kind_next == KIND_MEM_LO || kind_next == KIND_STATUS) begin
        latch_next = 1'b0;
      end
      kind_next = KIND_NONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      evt_prev_reg     <= 3'h0;
      latch_reg        <= STATUS_RESET[ST_LATCH_POS];
      bp_reg           <= 2'h0;
      kind_reg         <= KIND_NONE;
      write_latch_flag <= 1'b0;
    end else begin
      evt_prev_reg     <= evt_prev_next;
      latch_reg        <= latch_next;
      bp_reg           <= bp_next;
      kind_reg         <= kind_next;
      write_latch_flag <= latch_next;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  property p_set_latch;
    @(posedge mclk) disable iff (rst)
    (opc_evt && opcode_reg == OPC_SET_LATCH && !frame_end)
      |=> latch_reg && status_q[ST_LATCH_POS];
  endproperty
  a_set_latch: assert property (p_set_latch)
    else $error("latch not set by set-latch opcode");

  property p_status_keeps_latch;
    @(posedge mclk) disable iff (rst)
    (sr_evt && !opc_evt && !frame_end) |=> $stable(latch_reg);
  endproperty
  a_status_keeps_latch: assert property (p_status_keeps_latch)
    else $error("status write changed latch");

  property p_auto_clear;
    @(posedge mclk) disable iff (rst)
    (frame_end && !opc_evt &&
     (kind_reg == KIND_MEM_LO || kind_reg == KIND_STATUS))
      |=> !latch_reg ##1 !write_latch_flag;
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("latch not cleared after write");

  property p_reset_zero;
    @(posedge mclk) rst |=> (status_q == STATUS_RESET);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("status not zero after reset");

  property p_hi_keeps_latch;
    @(posedge mclk) disable iff (rst)
    (frame_end && !opc_evt && kind_reg == KIND_MEM_HI && latch_reg)
      |=> latch_reg [*2];
  endproperty
  a_hi_keeps_latch: assert property (p_hi_keeps_latch)
    else $error("upper write cleared latch");

  property p_clear_cmd;
    @(posedge mclk) disable iff (rst)
    (opc_evt && opcode_reg == OPC_CLR_LATCH) |=> !latch_reg;
  endproperty
  a_clear_cmd: assert property (p_clear_cmd)
    else $error("latch not cleared by clear-latch opcode");

  property p_refuse_status;
    @(posedge mclk) disable iff (rst)
    (sr_evt && !opc_evt && !latch_reg) |=> $stable(bp_reg);
  endproperty
  a_refuse_status: assert property (p_refuse_status)
    else $error("status written with latch clear");

  property p_addr_msb;
    @(posedge sclk) disable iff (cs_n)
    (byte_done && phase_reg == PH_OPCODE &&
     (is_mem_write(byte_in) || is_mem_read(byte_in)))
      |=> addr_reg[ADDR_W-1] == $past(si, 4) && phase_reg == PH_ADDR;
  endproperty
  a_addr_msb: assert property (p_addr_msb)
    else $error("ninth address bit not from opcode");

endmodule

// >>> tb/spi_host_model.sv
`timescale 1ns/1ns
// ******************************************************************
// SPI host model, mode 0: link clock runs only inside frames
// ******************************************************************
module spi_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so_out,
  input  wire logic so_oe
);
  import fram_pkg::*;

  // Select dips for a moment at start so its first rise clears the
  // link state of the device at a known time
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    si   = 1'b0;
    #1 cs_n = 1'b1;
  end

  // One frame of n bytes, first byte in tx[31:24], MSB first
  task automatic xfer(input logic [31:0] tx, input int n,
                      output logic [31:0] rx);
    int i;
    rx = 32'h0;
    #7 cs_n = 1'b0;
    #10;
    for (i = 0; i < n * 8; i++) begin
      si = tx[31-i];
      #32 sclk = 1'b1;
      // Undriven output reads as unknown so a dead enable shows
      rx[31-i] = so_oe ? so_out : 1'bx;
      #32 sclk = 1'b0;
    end
    #10 cs_n = 1'b1;
    // Deselected line shows no stale bit
    si = ~si;
    // Gap of ten control clocks lets the frame end cross over
    #200;
  endtask

  // Write frame followed by a separate clear-latch frame
  task automatic disarm_write(input logic [31:0] tx, input int n);
    logic [31:0] r;
    xfer(tx, n, r);
    xfer({OPC_CLR_LATCH, 24'h0}, 1, r);
  endtask
endmodule

// >>> tb/spi_fram_write_latch_ctrl_tb_top.sv
`timescale 1ns/1ns
// ******************************************************************
// Self-checking bench of the write latch control block
// ******************************************************************
module spi_fram_write_latch_ctrl_tb_top;
  import fram_pkg::*;

  logic        mclk;
  logic        rst;
  logic        sclk;
  logic        cs_n;
  logic        si;
  logic        so_out;
  logic        so_oe;
  logic        write_latch_flag;
  logic [31:0] rx;
  int          mismatches;
  int          total_checks;

  // 50 MHz control clock
  always #10 mclk = ~mclk;

  spi_fram_write_latch_ctrl i_dut (
    .mclk             (mclk),
    .rst              (rst),
    .sclk             (sclk),
    .cs_n             (cs_n),
    .si               (si),
    .so_out           (so_out),
    .so_oe            (so_oe),
    .write_latch_flag (write_latch_flag)
  );

  spi_host_model i_host (
    .sclk   (sclk),
    .cs_n   (cs_n),
    .si     (si),
    .so_out (so_out),
    .so_oe  (so_oe)
  );

  // ******************************************************************
  // Shared helpers
  // ******************************************************************
  task automatic complete_run;
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Frames start just after a falling control clock edge
  task automatic cmd(input logic [31:0] tx, input int n);
    @(negedge mclk);
    i_host.xfer(tx, n, rx);
  endtask

  task automatic status_is(input logic [7:0] exp);
    cmd({OPC_STATUS_RD, 24'h0}, 2);
    chk(rx[23:16], exp);
  endtask

  task automatic flag_is(input logic exp);
    chk({7'h0, write_latch_flag}, {7'h0, exp});
  endtask

  task automatic arm;
    cmd({OPC_SET_LATCH, 24'h0}, 1);
  endtask

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_reset;
    flag_is(1'b0);
    status_is(8'h00);
  endtask

  // Low write clears the latch; the next write is dropped
  task automatic t_low_write;
    arm();
    flag_is(1'b1);
    status_is(8'h02);
    cmd({OPC_WRITE_LO, 8'h10, 8'h11, 8'h12}, 4);
    flag_is(1'b0);
    cmd({OPC_WRITE_LO, 8'h10, 8'h99, 8'h98}, 4);
    cmd({OPC_READ_LO, 8'h10, 16'h0}, 4);
    chk(rx[15:8], 8'h11);
    chk(rx[7:0], 8'h12);
  endtask

  // Upper write keeps the latch; one unarmed write gets through
  task automatic t_high_write;
    arm();
    cmd({OPC_WRITE_HI, 8'h10, 8'h77, 8'h0}, 3);
    flag_is(1'b1);
    cmd({OPC_WRITE_LO, 8'h20, 8'h55, 8'h0}, 3);
    flag_is(1'b0);
    cmd({OPC_READ_LO, 8'h20, 16'h0}, 3);
    chk(rx[15:8], 8'h55);
    cmd({OPC_READ_HI, 8'h10, 16'h0}, 3);
    chk(rx[15:8], 8'h77);
    cmd({OPC_READ_LO, 8'h10, 16'h0}, 3);
    chk(rx[15:8], 8'h11);
  endtask

  // Status write riding on the leftover latch
  task automatic t_status;
    arm();
    cmd({OPC_WRITE_HI, 8'h11, 8'h66, 8'h0}, 3);
    cmd({OPC_STATUS_WR, 8'hff, 16'h0}, 2);
    flag_is(1'b0);
    status_is(8'h0c);
    cmd({OPC_READ_HI, 8'h11, 16'h0}, 3);
    chk(rx[15:8], 8'h66);
  endtask

  // Workaround: clear-latch after an upper write blocks all writes
  task automatic t_disarm;
    arm();
    @(negedge mclk);
    i_host.disarm_write({OPC_WRITE_HI, 8'h12, 8'h21, 8'h0}, 3);
    flag_is(1'b0);
    cmd({OPC_WRITE_LO, 8'h11, 8'h44, 8'h0}, 3);
    cmd({OPC_STATUS_WR, 8'h00, 16'h0}, 2);
    status_is(8'h0c);
    cmd({OPC_READ_LO, 8'h11, 16'h0}, 3);
    chk(rx[15:8], 8'h12);
    cmd({OPC_READ_HI, 8'h12, 16'h0}, 3);
    chk(rx[15:8], 8'h21);
  endtask

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    mclk         = 1'b0;
    rst          = 1'b1;
    mismatches   = 0;
    total_checks = 0;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_reset();
    t_low_write();
    t_high_write();
    t_status();
    t_disarm();
    complete_run();
  end

  // Guard against a hung frame
  initial begin
    #500000;
    mismatches++;
    complete_run();
  end
endmodule
